/* hdl/dma_channel_regs.vh */
/*
 * Register indices, field positions, reset values and encodings of one DMA channel.
 * Assumes inclusion by the channel module and its bench.
 */
`ifndef DMA_CHANNEL_REGS_VH
`define DMA_CHANNEL_REGS_VH

// Printed halfword indices; register number = (index - base) / 2, byte address = 4 * number
`define BASE_IDX                32'h5000_3620
`define SOURCE_START_LOW_IDX    32'h5000_3620
`define SOURCE_START_HIGH_IDX   32'h5000_3622
`define DEST_START_LOW_IDX      32'h5000_3624
`define DEST_START_HIGH_IDX     32'h5000_3626
`define IRQ_MATCH_COUNT_IDX     32'h5000_3628
`define TRANSFER_LENGTH_IDX     32'h5000_362a
`define CHANNEL_CONTROL_IDX     32'h5000_362c
`define ITEM_INDEX_IDX          32'h5000_362e

// Reset value and control write mask
`define REG16_RESET             16'h0000
`define CTRL_WRITE_MASK         16'h3fff

// Channel control fields
`define CTRL_ON_BIT             0
`define CTRL_WIDTH_LSB          1
`define CTRL_WIDTH_MSB          2
`define CTRL_IRQ_EN_BIT         3
`define CTRL_TRIG_MODE_BIT      4
`define CTRL_DST_INC_BIT        5
`define CTRL_SRC_INC_BIT        6
`define CTRL_CIRCULAR_BIT       7
`define CTRL_PRIO_LSB           8
`define CTRL_PRIO_MSB           10
`define CTRL_IDLE_BIT           11
`define CTRL_FILL_BIT           12
`define CTRL_SENSE_BIT          13

// Transfer width encodings
`define WIDTH_BYTE              2'h0
`define WIDTH_HALF              2'h1
`define WIDTH_WORD              2'h2
`define WIDTH_RESERVED          2'h3

`endif

/* hdl/dma_channel_control.v */
/*
 * One DMA channel: AHB-Lite register slave, peripheral request synchroniser,
 * channel arbitration against the other channels, and a simple memory master.
 * Assumes: the memory port answers each request with a one-cycle dma_ack;
 * other channels present their active flag and priority; channel numbers
 * of the others equal their vector index.
 */
// Overview of operation
// - Source start address is upper and lower 16-bit halves joined.
// - Destination start address is two readable, writable 16-bit halves.
// - Interrupt after an item when match count equals index before increment.
// - Interrupt only produced while interrupt enable bit is set.
// - Transfers length plus one items.
// - Sense bit 0 means level requests, 1 means rising edges only.
// - Fill mode reads source once, writes it to every destination item.
// - Running fill transfer cannot be interrupted by other channels.
// - Idle bit 0 copies back to back, locking out lower masters.
// - Idle bit 1 inserts two wait cycles after each store outside fill mode.
// - Request-triggered channels ignore the idle bit.
// - Highest priority field wins among requesting channels.
// - Equal priority goes to the lowest channel number.
// - Without circular mode channel stops and clears its on bit.
// - Circular request-triggered channel restarts with index zero, stays on.
// - Enabled increments step by 1, 2 or 4 per width code.
// - Destination fixed unless destination increment is set.
// - Trigger mode 0 starts at once, 1 waits for requests.
// - Width codes 00, 01, 10 mean 1, 2, 4 bytes; 11 reserved.
// - Channel stays off while on bit is 0; writing 1 enables.
// - Source advances by width when source increment set, else fixed.
// - Read-only item index, back to zero when transfer completes.
// - Next addresses come from index, increment enables and width.
`timescale 1ns/1ps
`include "dma_channel_regs.vh"

module dma_channel_control #(
  parameter CHAN_NUM  = 0,
  parameter NUM_CHANS = 4
) (
  input  wire                     hclk,
  input  wire                     hresetn,
  input  wire                     hsel,
  input  wire [31:0]              haddr,
  input  wire [1:0]               htrans,
  input  wire                     hwrite,
  input  wire [2:0]               hsize,
  input  wire [31:0]              hwdata,
  input  wire                     hready,
  output wire                     hreadyout,
  output wire                     hresp,
  output wire [31:0]              hrdata,
  input  wire                     periph_req,
  input  wire [NUM_CHANS-1:0]     other_bus_req,
  input  wire [3*NUM_CHANS-1:0]   other_prio,
  output wire                     ch_bus_req,
  output wire [2:0]               channel_priority,
  output wire                     bus_lock,
  output wire                     dma_req,
  output wire                     dma_write,
  output wire [31:0]              dma_addr,
  output wire [1:0]               dma_size,
  output wire [31:0]              dma_wdata,
  input  wire [31:0]              dma_rdata,
  input  wire                     dma_ack,
  output wire                     channel_irq
);

  localparam S_IDLE  = 3'd0;
  localparam S_ARB   = 3'd1;
  localparam S_READ  = 3'd2;
  localparam S_WRITE = 3'd3;
  localparam S_GAP   = 3'd4;

  localparam [2:0] R_SRC_L = 3'd0;
  localparam [2:0] R_SRC_H = 3'd1;
  localparam [2:0] R_DST_L = 3'd2;
  localparam [2:0] R_DST_H = 3'd3;
  localparam [2:0] R_CNT   = 3'd4;
  localparam [2:0] R_LEN   = 3'd5;
  localparam [2:0] R_CTRL  = 3'd6;
  localparam [2:0] R_IDX   = 3'd7;

  reg  [15:0] src_lo_r;
  reg  [15:0] src_hi_r;
  reg  [15:0] dst_lo_r;
  reg  [15:0] dst_hi_r;
  reg  [15:0] cnt_r;
  reg  [15:0] len_r;
  reg  [15:0] ctrl_r;
  reg  [15:0] idx_r;
  reg  [2:0]  state_r;
  reg  [31:0] data_r;
  reg  [31:0] addr_r;
  reg         write_r;
  reg         fill_read_r;
  reg         pend_r;
  reg         irq_r;
  reg         req_s1_r;
  reg         req_s2_r;
  reg         req_s3_r;
  reg         req_f_r;
  reg         wr_pend_r;
  reg         map_r;
  reg  [2:0]  wa_r;
  reg  [31:0] hrdata_r;

  wire        acc;
  wire        on_bit;
  wire [1:0]  width;
  wire        trig_mode;
  wire        sense;
  wire        fill;
  wire        idle_ins;
  wire        circular;
  wire        go;
  wire        won;
  wire        last;
  wire        can_stop;
  wire [31:0] src_addr;
  wire [31:0] dst_addr;
  wire [31:0] src_start;
  wire [31:0] dst_start;

  // Start plus index shifted by width code, or start alone when inc is clear
  function [31:0] item_addr;
    input [31:0] start;
    input        inc;
    input [15:0] index;
    input [1:0]  wcode;
    reg   [31:0] off;
    begin
      off       = {16'h0000, index} << wcode;
      item_addr = inc ? start + off : start;
    end
  endfunction

  assign acc       = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  assign on_bit    = ctrl_r[`CTRL_ON_BIT];
  assign width     = ctrl_r[`CTRL_WIDTH_MSB:`CTRL_WIDTH_LSB];
  assign trig_mode = ctrl_r[`CTRL_TRIG_MODE_BIT];
  assign sense     = ctrl_r[`CTRL_SENSE_BIT];
  assign fill      = ctrl_r[`CTRL_FILL_BIT];
  assign idle_ins  = ctrl_r[`CTRL_IDLE_BIT] & ~trig_mode;
  assign circular  = ctrl_r[`CTRL_CIRCULAR_BIT] & trig_mode;
  assign channel_priority = ctrl_r[`CTRL_PRIO_MSB:`CTRL_PRIO_LSB];

  assign src_start = {src_hi_r, src_lo_r};
  assign dst_start = {dst_hi_r, dst_lo_r};

  assign src_addr = item_addr(src_start, ctrl_r[`CTRL_SRC_INC_BIT] & ~fill, idx_r, width);
  assign dst_addr = item_addr(dst_start, ctrl_r[`CTRL_DST_INC_BIT], idx_r, width);

  assign go = ~trig_mode | (sense ? pend_r : req_f_r);

  reg beaten;
  integer k;
  always @* begin
    beaten = 1'b0;
    for (k = 0; k < NUM_CHANS; k = k + 1) begin
      if (k != CHAN_NUM && other_bus_req[k]) begin
        if (other_prio[3*k +: 3] > channel_priority) begin
          beaten = 1'b1;
        end else if (other_prio[3*k +: 3] == channel_priority && k < CHAN_NUM) begin
          beaten = 1'b1;
        end
      end
    end
  end
  assign won = ~beaten | (fill & fill_read_r);

  assign ch_bus_req = (state_r == S_ARB);
  // lower masters locked out while blocking
  assign bus_lock   = (state_r != S_IDLE) & (~idle_ins | fill);

  assign dma_req   = (state_r == S_READ) | (state_r == S_WRITE);
  assign dma_write = write_r;
  assign dma_addr  = addr_r;
  assign dma_size  = width;
  assign dma_wdata = data_r;
  assign channel_irq = irq_r;

  // last item at index equal to length
  assign last     = (idx_r == len_r);
  assign can_stop = (state_r == S_IDLE) | (state_r == S_ARB) | (state_r == S_GAP);

  // Three-stage request synchroniser; a change counts when stages two and three agree
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      req_f_r  <= 1'b0;
    end else begin
      req_s1_r <= periph_req;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      if (req_s2_r == req_s3_r) begin
        req_f_r <= req_s3_r;
      end
    end
  end

  // Register read mux
  reg [31:0] rd_val;
  always @* begin
    case (haddr[4:2])
      R_SRC_L: rd_val = {16'h0000, src_lo_r};
      R_SRC_H: rd_val = {16'h0000, src_hi_r};
      R_DST_L: rd_val = {16'h0000, dst_lo_r};
      R_DST_H: rd_val = {16'h0000, dst_hi_r};
      R_CNT:   rd_val = {16'h0000, cnt_r};
      R_LEN:   rd_val = {16'h0000, len_r};
      R_CTRL:  rd_val = {16'h0000, ctrl_r};
      R_IDX:   rd_val = {16'h0000, idx_r};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // AHB-Lite address phase capture; read data prepared a cycle early
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      map_r     <= 1'b0;
      wa_r      <= 3'h0;
      hrdata_r  <= 32'h0000_0000;
    end else begin
      wr_pend_r <= acc & hwrite;
      if (acc) begin
        map_r <= (haddr[31:5] == 27'h000_0000);
        wa_r  <= haddr[4:2];
        if (!hwrite && haddr[31:5] == 27'h000_0000) begin
          hrdata_r <= rd_val;
        end else begin
          hrdata_r <= 32'h0000_0000;
        end
      end
    end
  end

  wire sw_wr = wr_pend_r & map_r;

  // Channel engine and register file
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_lo_r    <= `REG16_RESET;
      src_hi_r    <= `REG16_RESET;
      dst_lo_r    <= `REG16_RESET;
      dst_hi_r    <= `REG16_RESET;
      cnt_r       <= `REG16_RESET;
      len_r       <= `REG16_RESET;
      ctrl_r      <= `REG16_RESET;
      idx_r       <= `REG16_RESET;
      state_r     <= S_IDLE;
      data_r      <= 32'h0000_0000;
      addr_r      <= 32'h0000_0000;
      write_r     <= 1'b0;
      fill_read_r <= 1'b0;
      pend_r      <= 1'b0;
      irq_r       <= 1'b0;
    end else begin
      irq_r <= 1'b0;
      // edge requests remembered; a new edge beats consumption
      if (state_r == S_IDLE && on_bit && go && trig_mode) begin
        pend_r <= 1'b0;
      end
      if (req_s3_r && !req_f_r && req_s2_r && sense) begin
        pend_r <= 1'b1;
      end
      case (state_r)
        S_IDLE: begin
          // idle while off or width reserved
          if (on_bit && width != `WIDTH_RESERVED && go) begin
            state_r <= S_ARB;
          end
        end
        S_ARB: begin
          if (won) begin
            // single source fetch in fill mode
            if (fill && fill_read_r) begin
              state_r <= S_WRITE;
              addr_r  <= dst_addr;
              write_r <= 1'b1;
            end else begin
              state_r <= S_READ;
              addr_r  <= src_addr;
              write_r <= 1'b0;
            end
          end
        end
        S_READ: begin
          if (dma_ack) begin
            data_r      <= dma_rdata;
            fill_read_r <= fill;
            addr_r      <= dst_addr;
            write_r     <= 1'b1;
            state_r     <= S_WRITE;
          end
        end
        S_WRITE: begin
          if (dma_ack) begin
            write_r <= 1'b0;
            irq_r <= ctrl_r[`CTRL_IRQ_EN_BIT] & (cnt_r == idx_r);
            if (last) begin
              idx_r       <= 16'h0000;
              fill_read_r <= 1'b0;
              if (!circular) begin
                ctrl_r[`CTRL_ON_BIT] <= 1'b0;
              end
            end else begin
              idx_r <= idx_r + 16'h0001;
            end
            if (idle_ins && !fill) begin
              state_r <= S_GAP;
            end else if (!last && !trig_mode) begin
              state_r <= S_ARB;
            end else begin
              state_r <= S_IDLE;
            end
          end
        end
        S_GAP: begin
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
      if (!on_bit && can_stop) begin
        state_r     <= S_IDLE;
        idx_r       <= 16'h0000;
        fill_read_r <= 1'b0;
      end
      // Software write last, so a set written with a hardware clear survives
      if (sw_wr) begin
        case (wa_r)
          R_SRC_L: src_lo_r <= hwdata[15:0];
          R_SRC_H: src_hi_r <= hwdata[15:0];
          R_DST_L: dst_lo_r <= hwdata[15:0];
          R_DST_H: dst_hi_r <= hwdata[15:0];
          R_CNT:   cnt_r    <= hwdata[15:0];
          R_LEN:   len_r    <= hwdata[15:0];
          R_CTRL:  ctrl_r   <= hwdata[15:0] & `CTRL_WRITE_MASK;
          default: ;
        endcase
      end
    end
  end

endmodule // dma_channel_control

/* testbench/mem_model.sv */
/* Memory behind the channel's master port.
   Assumes requests stay up until acknowledged; dly sets the answer delay. */
`timescale 1ns/1ps
module mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [3:0]  dly,
  input  wire logic        dma_req,
  input  wire logic        dma_write,
  input  wire logic [31:0] dma_addr,
  input  wire logic [31:0] dma_wdata,
  output logic      [31:0] dma_rdata,
  output logic             dma_ack
);
  logic [31:0] wa [0:63];
  logic [31:0] wd [0:63];
  int          wn;
  int          rn;
  logic [3:0]  cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_ack <= 1'b0;
      dma_rdata <= 32'h0000_0000;
      cnt <= 4'h0;
      wn <= 0;
      rn <= 0;
    end else begin
      dma_ack <= 1'b0;
      // Read data is garbage outside the ack cycle, never the last value
      dma_rdata <= ~dma_rdata;
      if (dma_req && !dma_ack) begin
        if (cnt == dly) begin
          cnt <= 4'h0;
          dma_ack <= 1'b1;
          if (dma_write) begin
            wa[wn%64] <= dma_addr;
            wd[wn%64] <= dma_wdata;
            wn <= wn + 1;
          end else begin
            dma_rdata <= {dma_addr[15:0], ~dma_addr[15:0]};
            rn <= rn + 1;
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // mem_model

/* testbench/dma_channel_sva.sv */
/* Port checker for one DMA channel.
   Assumes a single clock hclk and reset hresetn; bound to every channel. */
`timescale 1ns/1ps
module dma_channel_sva #(
  parameter CHAN_NUM  = 0,
  parameter NUM_CHANS = 4
) (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic [31:0]            hrdata,
  input wire logic [NUM_CHANS-1:0]   other_bus_req,
  input wire logic [3*NUM_CHANS-1:0] other_prio,
  input wire logic                   ch_bus_req,
  input wire logic [2:0]             channel_priority,
  input wire logic                   dma_req,
  input wire logic                   dma_write,
  input wire logic [31:0]            dma_addr,
  input wire logic [1:0]             dma_size,
  input wire logic [31:0]            dma_wdata,
  input wire logic [31:0]            dma_rdata,
  input wire logic                   dma_ack,
  input wire logic                   channel_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic beaten;
  // Fill runs must not see competing requests, the checker cannot tell
  always_comb begin
    beaten = 1'b0;
    for (int k = 0; k < NUM_CHANS; k++) begin
      if (k != CHAN_NUM && other_bus_req[k] && (other_prio[3*k+:3] > channel_priority ||
          (other_prio[3*k+:3] == channel_priority && k < CHAN_NUM)))
        beaten = 1'b1;
    end
  end
  a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_req_held: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr)
    && $stable(dma_write) && $stable(dma_wdata)) else $error("request dropped early");
  a_store_follows: assert property (dma_req && dma_ack && !dma_write |=> dma_req
    && dma_write && dma_wdata[7:0] == $past(dma_rdata[7:0])) else $error("bad store");
  a_arb_lose: assert property (ch_bus_req && beaten |=> !dma_req)
    else $error("won against stronger channel");
  a_arb_win: assert property (ch_bus_req && !beaten |=> dma_req
    && (!dma_write || $stable(dma_wdata))) else $error("grant not taken");
  a_size_legal: assert property (dma_req |-> dma_size != 2'h3)
    else $error("reserved width used");
  a_irq_cause: assert property (channel_irq |-> $past(dma_ack && dma_write)
    || $past(dma_ack && dma_write, 2)) else $error("interrupt without store");
  a_irq_single: assert property (channel_irq |=> !channel_irq)
    else $error("interrupt longer than one cycle");
  cover property (channel_irq);
  cover property (ch_bus_req && beaten);
  cover property (dma_ack && dma_write);
endmodule // dma_channel_sva
bind dma_channel_control dma_channel_sva #(.CHAN_NUM(CHAN_NUM), .NUM_CHANS(NUM_CHANS))
  dma_channel_sva_i (.hclk, .hresetn, .hrdata, .other_bus_req, .other_prio, .ch_bus_req,
  .channel_priority, .dma_req, .dma_write, .dma_addr, .dma_size, .dma_wdata, .dma_rdata,
  .dma_ack, .channel_irq);

/* testbench/dma_channel_control_tb.sv */
/* Bench for DMA channel 1 of four: registers over AHB-Lite, transfers
   against the memory model. Assumes the zero-wait register slave. */
`timescale 1ns/1ps
`include "dma_channel_regs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module dma_channel_control_tb;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, periph_req = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [3:0]  dly = 0, other_bus_req = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  wire         hreadyout, hresp, ch_bus_req, bus_lock, dma_req, dma_write, dma_ack, channel_irq;
  wire  [2:0]  channel_priority;
  wire  [1:0]  dma_size;
  wire  [31:0] hrdata, dma_addr, dma_wdata, dma_rdata;
  // Priorities: ch3 5, ch2 2, ch0 3; own field set by software
  wire  [11:0] other_prio = 12'ha83;
  int          fail_count = 0, check_count = 0, irqn = 0, cyc = 0;
  dma_channel_control #(.CHAN_NUM(1), .NUM_CHANS(4)) dma_channel_control_i (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .periph_req, .other_bus_req, .other_prio, .ch_bus_req, .channel_priority,
    .bus_lock, .dma_req, .dma_write, .dma_addr, .dma_size, .dma_wdata, .dma_rdata, .dma_ack,
    .channel_irq);
  mem_model mem_model_i (.hclk, .hresetn, .dly, .dma_req, .dma_write, .dma_addr, .dma_wdata,
    .dma_rdata, .dma_ack);
  initial begin
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (channel_irq === 1'b1)
      irqn = irqn + 1;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  function automatic [31:0] ba(input [31:0] idx);
    return 2 * (idx - `BASE_IDX);
  endfunction
  task automatic wr(input [31:0] idx, input [15:0] d);
    logic [31:0] q;
    bus(1'b1, ba(idx), d, q);
  endtask
  task automatic rd(input [31:0] idx, output [31:0] q);
    bus(1'b0, ba(idx), 16'h0000, q);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    int          r0;
    for (int i = 0; i < 8; i++) begin
      rd(`BASE_IDX + 2 * i, q);
      `CHK("reset value", 32'h0000_0000, q)
    end
    for (int i = 0; i < 6; i++) begin
      wr(`BASE_IDX + 2 * i, 16'h1234 + 16'h1111 * i);
      rd(`BASE_IDX + 2 * i, q);
      `CHK("read back", 32'h1234 + 32'h1111 * i, q)
    end
    r0 = mem_model_i.rn;
    wr(`CHANNEL_CONTROL_IDX, 16'hefff);
    repeat (10) @(posedge hclk);
    `CHK("reserved width idle", r0, mem_model_i.rn)
    rd(`CHANNEL_CONTROL_IDX, q);
    `CHK("control bits", 32'h0000_2fff, q)
    wr(`CHANNEL_CONTROL_IDX, 16'h0000);
    wr(`ITEM_INDEX_IDX, 16'h00ff);
    rd(`ITEM_INDEX_IDX, q);
    `CHK("index read only", 32'h0000_0000, q)
    bus(1'b1, 32'h0000_0040, 16'h5555, q);
    bus(1'b0, 32'h0000_0040, 16'h0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    `CHK("okay response", 1'b0, hresp)
    $display("register test done");
  endtask
  task automatic xfer(input [15:0] ctl, input [15:0] len, input [15:0] ic, input int blk,
                      input [3:0] om, input [31:0] src, input [31:0] dst);
    logic [31:0] q, m;
    int          n, ss, ds, r0, w0, i0;
    n = 1 << ctl[2:1];
    m = (64'h1 << (8 * n)) - 1;
    ss = (ctl[6] && !ctl[12]) ? n : 0;
    ds = ctl[5] ? n : 0;
    wr(`SOURCE_START_LOW_IDX, src[15:0]);
    wr(`SOURCE_START_HIGH_IDX, src[31:16]);
    wr(`DEST_START_LOW_IDX, dst[15:0]);
    wr(`DEST_START_HIGH_IDX, dst[31:16]);
    wr(`IRQ_MATCH_COUNT_IDX, ic);
    wr(`TRANSFER_LENGTH_IDX, len);
    r0 = mem_model_i.rn;
    w0 = mem_model_i.wn;
    i0 = irqn;
    other_bus_req <= om;
    wr(`CHANNEL_CONTROL_IDX, ctl | 16'h0001);
    repeat (blk) @(posedge hclk);
    `CHK("fetch while held", r0, mem_model_i.rn)
    `CHK("bus lock", (blk > 0 && !ctl[4] && !ctl[11]), bus_lock)
    other_bus_req <= 4'h0;
    periph_req <= 1'b1;
    q = 32'h1;
    for (int i = 0; i < 100 && q[0] !== 1'b0; i++)
      rd(`CHANNEL_CONTROL_IDX, q);
    `CHK("on bit cleared", 1'b0, q[0])
    periph_req <= 1'b0;
    for (int k = 0; k <= len; k++) begin
      `CHK("store addr", dst + k * ds, mem_model_i.wa[(w0 + k) % 64])
      `CHK("store data", {src[15:0] + 16'(k * ss), ~(src[15:0] + 16'(k * ss))} & m,
        mem_model_i.wd[(w0 + k) % 64] & m)
    end
    `CHK("store count", len + 1, mem_model_i.wn - w0)
    `CHK("fetch count", ctl[12] ? 1 : len + 1, mem_model_i.rn - r0)
    `CHK("irq count", (ctl[3] && ic <= len) ? 1 : 0, irqn - i0)
    rd(`ITEM_INDEX_IDX, q);
    `CHK("index", 32'h0000_0000, q)
    $display("transfer %h done", ctl);
  endtask
  task automatic t_circ;
    logic [31:0] q;
    int          w0;
    w0 = mem_model_i.wn;
    wr(`DEST_START_LOW_IDX, 16'h0300);
    wr(`DEST_START_HIGH_IDX, 16'h0000);
    wr(`TRANSFER_LENGTH_IDX, 16'h0000);
    wr(`CHANNEL_CONTROL_IDX, 16'h20f5);
    for (int p = 0; p < 3; p++) begin
      periph_req <= 1'b1;
      repeat (20) @(posedge hclk);
      periph_req <= 1'b0;
      repeat (8) @(posedge hclk);
    end
    `CHK("edge items", 3, mem_model_i.wn - w0)
    `CHK("circular addr", 32'h0000_0300, mem_model_i.wa[(w0 + 2) % 64])
    rd(`CHANNEL_CONTROL_IDX, q);
    `CHK("circular on", 32'h0000_20f5, q)
    wr(`CHANNEL_CONTROL_IDX, 16'h0000);
    $display("circular test done");
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    xfer(16'h036c, 16'h0002, 16'h0001, 0, 4'h0, 32'h1234_0100, 32'h5678_0200);
    dly <= 4'h2;
    xfer(16'h0b28, 16'h0003, 16'h0003, 0, 4'h0, 32'h0000_1001, 32'h0000_2003);
    dly <= 4'h0;
    xfer(16'h0342, 16'h0001, 16'h0000, 0, 4'h0, 32'h0000_1100, 32'h0000_2100);
    xfer(16'h132c, 16'h0002, 16'h0002, 0, 4'h0, 32'h0000_1200, 32'h0000_2200);
    xfer(16'h036c, 16'h0000, 16'h0000, 10, 4'h1, 32'h0000_1300, 32'h0000_2300);
    xfer(16'h036c, 16'h0000, 16'h0000, 10, 4'h8, 32'h0000_1400, 32'h0000_2400);
    xfer(16'h0b74, 16'h0001, 16'h0001, 10, 4'h0, 32'h0000_1500, 32'h0000_2500);
    t_circ;
    wrap_up;
  end
endmodule // dma_channel_control_tb
